// ---- hdl/sadc_conv_readout.sv ----
// Overview of operation
// - Trigger rise after acquisition starts a conversion.
// - CMOS or differential trigger behave identically.
// - Sixteen binary-weighted steps, MSB first.
// - Result readable only after first-bit-ready time.
// - One bit advances per read clock pulse.
// - Echoed-clock and self-clocked readout modes.
// - Sixteen-bit two's-complement word, MSB first.
// - Zero maps 0x0000, extremes 0x7FFF, 0x8000.
// - Both select inputs low powers down.
// - Triggers during conversion are ignored.
// - Data changes on read clock falling edge.
`timescale 1ns/1ns
module sadc_conv_readout (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        read_clock,
  input  wire logic        conversion_trigger_p,
  input  wire logic        conversion_trigger_n,
  input  wire logic        trigger_is_lvds,
  input  wire logic        ref_mode_select_lo,
  input  wire logic        ref_mode_select_hi,
  input  wire logic        echo_leg_grounded,
  input  wire logic [15:0] sample_code,
  output logic             serial_data,
  output logic             echoed_read_clock,
  output logic             powered_down,
  output logic             busy
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic trig_p_s;
  logic trig_n_s;
  logic lo_clear_s;
  logic hi_clear_s;
  logic lvds_s;
  logic echo_gnd_s;

  sadc_sync2 u_sync_tp (.clk(clock), .rst_n(rst_n), .din(conversion_trigger_p),
                        .dout(trig_p_s));
  sadc_sync2 u_sync_tn (.clk(clock), .rst_n(rst_n), .din(conversion_trigger_n),
                        .dout(trig_n_s));
  sadc_sync2 u_sync_lo (.clk(clock), .rst_n(rst_n), .din(!ref_mode_select_lo),
                        .dout(lo_clear_s));
  sadc_sync2 u_sync_hi (.clk(clock), .rst_n(rst_n), .din(!ref_mode_select_hi),
                        .dout(hi_clear_s));
  sadc_sync2 u_sync_lv (.clk(clock), .rst_n(rst_n), .din(trigger_is_lvds),
                        .dout(lvds_s));
  sadc_sync2 u_sync_eg (.clk(read_clock), .rst_n(rst_n), .din(echo_leg_grounded),
                        .dout(echo_gnd_s));

  // ----------------------------------------------------------------------
  // Trigger decode and conversion control
  // ----------------------------------------------------------------------
  logic                    trig_lvl;
  logic                    trig_prev_q;
  logic                    trig_prev_d;
  logic                    trig_rise;
  logic                    down_req;
  sadc_pkg::sadc_state_type state_q;
  sadc_pkg::sadc_state_type state_d;
  logic [4:0]              step_q;
  logic [4:0]              step_d;
  logic [7:0]              wait_q;
  logic [7:0]              wait_d;
  logic [15:0]             sampled_q;
  logic [15:0]             sampled_d;
  logic [15:0]             trial_q;
  logic [15:0]             trial_d;
  logic [15:0]             result_q;
  logic [15:0]             result_d;
  logic                    pub_tog_q;
  logic                    pub_tog_d;
  logic [15:0]             offset_code;
  logic [15:0]             trial_bit;

  always_comb
  begin
    trig_lvl = lvds_s ? (trig_p_s & ~trig_n_s) : trig_p_s;
    trig_rise = trig_lvl & ~trig_prev_q;
    trig_prev_d = trig_lvl;
    down_req = lo_clear_s & hi_clear_s;
    offset_code = sample_code ^ sadc_pkg::RES_MSB_MASK;
    trial_bit = sadc_pkg::RES_MSB_MASK >> step_q;
    state_d = state_q;
    step_d = step_q;
    wait_d = wait_q;
    sampled_d = sampled_q;
    trial_d = trial_q;
    result_d = result_q;
    pub_tog_d = pub_tog_q;
    case (state_q)
      sadc_pkg::SADC_IDLE:
      begin
        if (down_req)
        begin
          state_d = sadc_pkg::SADC_DOWN;
        end
        else if (trig_rise)
        begin
          sampled_d = offset_code;
          trial_d = sadc_pkg::RES_RESET;
          step_d = 5'h00;
          wait_d = 8'h00;
          state_d = sadc_pkg::SADC_SAR;
        end
      end
      sadc_pkg::SADC_SAR:
      begin
        wait_d = wait_q + 8'h01;
        if ((trial_q | trial_bit) <= sampled_q)
        begin
          trial_d = trial_q | trial_bit;
        end
        step_d = step_q + 5'h01;
        if (step_q == sadc_pkg::SAR_LAST_STEP)
        begin
          state_d = sadc_pkg::SADC_WAIT;
        end
      end
      sadc_pkg::SADC_WAIT:
      begin
        wait_d = wait_q + 8'h01;
        if (wait_q >= sadc_pkg::READY_LAST)
        begin
          result_d = trial_q ^ sadc_pkg::RES_MSB_MASK;
          pub_tog_d = ~pub_tog_q;
          state_d = sadc_pkg::SADC_IDLE;
        end
      end
      sadc_pkg::SADC_DOWN:
      begin
        if (!down_req)
        begin
          state_d = sadc_pkg::SADC_IDLE;
        end
      end
      default:
      begin
        state_d = sadc_pkg::SADC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= sadc_pkg::SADC_IDLE;
      trig_prev_q <= 1'b0;
      step_q <= 5'h00;
      wait_q <= 8'h00;
      sampled_q <= sadc_pkg::RES_RESET;
      trial_q <= sadc_pkg::RES_RESET;
      result_q <= sadc_pkg::RES_RESET;
      pub_tog_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      trig_prev_q <= trig_prev_d;
      step_q <= step_d;
      wait_q <= wait_d;
      sampled_q <= sampled_d;
      trial_q <= trial_d;
      result_q <= result_d;
      pub_tog_q <= pub_tog_d;
    end
  end

  assign busy = (state_q == sadc_pkg::SADC_SAR) || (state_q == sadc_pkg::SADC_WAIT);
  assign powered_down = (state_q == sadc_pkg::SADC_DOWN);

  // ----------------------------------------------------------------------
  // Two-entry buffer toward the link
  // ----------------------------------------------------------------------
  logic        pub_s1_q;
  logic        pub_s2_q;
  logic        pub_s3_q;
  logic        in_valid;
  logic        in_ready;
  logic [15:0] buf_q [2];
  logic [15:0] buf_d [2];
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  logic        out_valid;
  logic        out_ready;

  always_ff @(posedge read_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pub_s1_q <= 1'b0;
      pub_s2_q <= 1'b0;
      pub_s3_q <= 1'b0;
    end
    else
    begin
      pub_s1_q <= pub_tog_q;
      pub_s2_q <= pub_s1_q;
      pub_s3_q <= pub_s2_q;
    end
  end

  always_comb
  begin
    in_valid = pub_s2_q ^ pub_s3_q;
    in_ready = (cnt_q != 2'd2) || out_ready;
    out_valid = (cnt_q != 2'd0);
    buf_d = buf_q;
    cnt_d = cnt_q;
    if (out_valid && out_ready)
    begin
      buf_d[0] = buf_q[1];
      cnt_d = cnt_q - 2'd1;
    end
    if (in_valid && in_ready)
    begin
      buf_d[cnt_d[0]] = result_q;
      cnt_d = cnt_d + 2'd1;
    end
  end

  always_ff @(posedge read_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_q[0] <= sadc_pkg::RES_RESET;
      buf_q[1] <= sadc_pkg::RES_RESET;
      cnt_q <= 2'd0;
    end
    else
    begin
      buf_q <= buf_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------------
  // Serial shifter on the read clock
  // ----------------------------------------------------------------------
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [4:0]  left_q;
  logic [4:0]  left_d;
  logic        data_q;
  logic        data_d;

  always_comb
  begin
    shift_d = shift_q;
    left_d = left_q;
    out_ready = (left_q == 5'd0) || (left_q == 5'd1);
    if (left_q != 5'd0)
    begin
      shift_d = {shift_q[14:0], 1'b0};
      left_d = left_q - 5'd1;
    end
    if (out_valid && out_ready)
    begin
      shift_d = buf_q[0];
      left_d = 5'd16;
    end
  end

  always_ff @(posedge read_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_q <= sadc_pkg::RES_RESET;
      left_q <= 5'd0;
    end
    else
    begin
      shift_q <= shift_d;
      left_q <= left_d;
    end
  end

  always_comb
  begin
    data_d = (left_q != 5'd0) ? shift_q[15] : 1'b0;
  end

  always_ff @(negedge read_clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_q <= 1'b0;
    end
    else
    begin
      data_q <= data_d;
    end
  end

  assign serial_data = data_q;
  assign echoed_read_clock = echo_gnd_s ? 1'b0 : read_clock;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sar_steps_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == sadc_pkg::SADC_IDLE && !down_req && trig_rise) |=>
    (state_q == sadc_pkg::SADC_SAR && step_q == 5'h00) ##15
    (state_q == sadc_pkg::SADC_SAR && step_q == sadc_pkg::SAR_LAST_STEP) ##1
    (state_q == sadc_pkg::SADC_WAIT))
    else $error("SAR did not take sixteen steps.");
  ignore_trig_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state_q == sadc_pkg::SADC_SAR && trig_rise) |=> $stable(sampled_q))
    else $error("Trigger during conversion disturbed the sample.");
  ready_time_a: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(pub_tog_q) |-> $past(wait_q) >= sadc_pkg::READY_LAST)
    else $error("Result published before first bit ready.");
  code_map_a: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(pub_tog_q) |-> result_q == (trial_q ^ sadc_pkg::RES_MSB_MASK))
    else $error("Output code mapping wrong.");
  power_down_a: assert property (@(posedge clock) disable iff (!rst_n)
    (down_req && state_q == sadc_pkg::SADC_IDLE) |=> powered_down)
    else $error("Power-down not entered.");
  shift_step_a: assert property (@(posedge read_clock) disable iff (!rst_n)
    (left_q > 5'd1) |=> left_q == $past(left_q) - 5'd1)
    else $error("Shifter skipped a bit.");
  msb_first_a: assert property (@(posedge read_clock) disable iff (!rst_n)
    (out_valid && out_ready) |=> shift_q == $past(buf_q[0]))
    else $error("Word not loaded MSB first.");
  echo_mode_a: assert property (@(negedge read_clock) disable iff (!rst_n)
    echoed_read_clock == !echo_gnd_s)
    else $error("Echoed clock driven in self-clocked mode.");

endmodule : sadc_conv_readout

// ---- hdl/sadc_pkg.sv ----
package sadc_pkg;

  // ----------------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------------
  localparam int unsigned RES_BITS        = 16;
  localparam logic [15:0] RES_RESET       = 16'h0000;
  localparam logic [15:0] RES_MAX_POS     = 16'h7FFF;
  localparam logic [15:0] RES_MIN_NEG     = 16'h8000;
  localparam logic [15:0] RES_MSB_MASK    = 16'h8000;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned FIRST_BIT_READY_TIME_NS = 100;
  localparam int unsigned FIRST_BIT_READY_CYC =
    (FIRST_BIT_READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SAR_STEPS       = 16;
  localparam logic [4:0]  SAR_LAST_STEP   = 5'h0F;
  localparam logic [7:0]  READY_LAST      = 8'(FIRST_BIT_READY_CYC - 1);

  // ----------------------------------------------------------------------
  // Conversion states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    SADC_IDLE  = 4'b0001,
    SADC_SAR   = 4'b0010,
    SADC_WAIT  = 4'b0100,
    SADC_DOWN  = 4'b1000
  } sadc_state_type;

endpackage : sadc_pkg

// ---- hdl/sadc_sync2.sv ----
`timescale 1ns/1ns
module sadc_sync2 (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb
  begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;

endmodule : sadc_sync2

// ---- tb/sadc_host_model.sv ----
`timescale 1ns/1ns
module sadc_host_model #(
  parameter int LEAD = 4
) (
  input  wire logic        start,
  input  wire logic        slow,
  input  wire logic        self_mode,
  input  wire logic        serial_data,
  input  wire logic        echoed_read_clock,
  output logic             read_clock,
  output logic [15:0]      word,
  output logic             done,
  output logic             echo_bad
);
  // ----------------------------------------------------------------------
  // Burst of the read clock, idle low between bursts
  // ----------------------------------------------------------------------
  initial
  begin
    read_clock = 1'b0;
    word       = 16'h0000;
    done       = 1'b1;
    echo_bad   = 1'b0;
    forever
    begin
      @(posedge start);
      done = 1'b0;
      #17;
      for (int i = 0; i < LEAD + 16; i++)
      begin
        read_clock = 1'b1;
        #1;
        if (i >= LEAD)
        begin
          word = {word[14:0], serial_data};
          if (echoed_read_clock !== !self_mode) echo_bad = 1'b1;
        end
        #39;
        read_clock = 1'b0;
        #40;
        if (slow && i == LEAD + 7) #400;
      end
      done = 1'b1;
    end
  end
endmodule : sadc_host_model

// ---- tb/tb_sar_adc_conversion_readout.sv ----
`timescale 1ns/1ns
module tb_sar_adc_conversion_readout;
  logic        clock;
  logic        rst_n;
  logic        read_clock;
  logic        conversion_trigger_p;
  logic        conversion_trigger_n;
  logic        trigger_is_lvds;
  logic        ref_mode_select_lo;
  logic        ref_mode_select_hi;
  logic        echo_leg_grounded;
  logic [15:0] sample_code;
  logic        serial_data;
  logic        echoed_read_clock;
  logic        powered_down;
  logic        busy;
  logic        start;
  logic        slow;
  logic [15:0] word;
  logic        done;
  logic        echo_bad;
  int          error_cnt;
  int          total_checks;
  logic [15:0] codes [6] = '{16'h0000, 16'h0001, 16'hFFFF, 16'h7FFF, 16'h8000, 16'h8001};

  sadc_conv_readout sadc_conv_readout_i (
    .clock(clock), .rst_n(rst_n), .read_clock(read_clock),
    .conversion_trigger_p(conversion_trigger_p), .conversion_trigger_n(conversion_trigger_n),
    .trigger_is_lvds(trigger_is_lvds), .ref_mode_select_lo(ref_mode_select_lo),
    .ref_mode_select_hi(ref_mode_select_hi), .echo_leg_grounded(echo_leg_grounded),
    .sample_code(sample_code), .serial_data(serial_data),
    .echoed_read_clock(echoed_read_clock), .powered_down(powered_down), .busy(busy));

  sadc_host_model sadc_host_model_i (
    .start(start), .slow(slow), .self_mode(echo_leg_grounded), .serial_data(serial_data),
    .echoed_read_clock(echoed_read_clock), .read_clock(read_clock), .word(word),
    .done(done), .echo_bad(echo_bad));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  task automatic pulse_trigger(logic [15:0] code);
    sample_code          <= code;
    conversion_trigger_p <= 1'b1;
    conversion_trigger_n <= !trigger_is_lvds;
    repeat (2) @(posedge clock);
    conversion_trigger_p <= 1'b0;
    conversion_trigger_n <= 1'b1;
  endtask : pulse_trigger

  task automatic convert(logic [15:0] code, logic retrig);
    int n;
    pulse_trigger(code);
    n = 0;
    while (busy !== 1'b1 && n < 10) begin @(negedge clock); n++; end
    chk("busy rise", 16'h0001, {15'h0000, busy});
    @(posedge clock);
    if (retrig) pulse_trigger(~code);
    n = 0;
    while (busy !== 1'b0 && n < 60) begin @(negedge clock); n++; end
    repeat (16) @(posedge clock);
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    repeat (2) @(posedge clock);
    n = 0;
    while (done !== 1'b1 && n < 600) begin @(negedge clock); n++; end
    chk("result", code, word);
    chk("echo", 16'h0000, {15'h0000, echo_bad});
    chk("idle data", 16'h0000, {15'h0000, serial_data});
    @(posedge clock);
  endtask : convert

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic coding_table;
    convert(16'h1234, 1'b0);
    foreach (codes[i]) convert(codes[i], 1'b0);
  endtask : coding_table

  task automatic lvds_self_slow;
    trigger_is_lvds   <= 1'b1;
    echo_leg_grounded <= 1'b1;
    slow              <= 1'b1;
    @(posedge clock);
    convert(16'hA5C3, 1'b0);
    trigger_is_lvds   <= 1'b0;
    echo_leg_grounded <= 1'b0;
    slow              <= 1'b0;
    @(posedge clock);
  endtask : lvds_self_slow

  task automatic retrigger;
    convert(16'h5A3C, 1'b1);
  endtask : retrigger

  task automatic power_down;
    for (int m = 0; m < 4; m++)
    begin
      {ref_mode_select_hi, ref_mode_select_lo} <= 2'(m);
      repeat (6) @(posedge clock);
      chk("powered down", 16'((m == 0) ? 1 : 0), {15'h0000, powered_down});
    end
    {ref_mode_select_hi, ref_mode_select_lo} <= 2'h0;
    repeat (6) @(posedge clock);
    pulse_trigger(16'h0F0F);
    repeat (10) @(posedge clock);
    chk("busy in power-down", 16'h0000, {15'h0000, busy});
    {ref_mode_select_hi, ref_mode_select_lo} <= 2'h3;
    repeat (6) @(posedge clock);
    convert(16'h0F0F, 1'b0);
  endtask : power_down

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  initial
  begin
    #200000;
    error_cnt++;
    stop_test;
  end

  initial
  begin
    error_cnt            = 0;
    total_checks         = 0;
    rst_n                = 1'b0;
    conversion_trigger_p = 1'b0;
    conversion_trigger_n = 1'b1;
    trigger_is_lvds      = 1'b0;
    ref_mode_select_lo   = 1'b1;
    ref_mode_select_hi   = 1'b1;
    echo_leg_grounded    = 1'b0;
    sample_code          = 16'h0000;
    start                = 1'b0;
    slow                 = 1'b0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    coding_table;
    lvds_self_slow;
    retrigger;
    power_down;
    stop_test;
  end
endmodule : tb_sar_adc_conversion_readout
